// >>> rtl/gpfg_pkg.sv
/*
 * gpfg_pkg: constants for the two small general-purpose ports.
 * Assumes an 8-bit register port with 4-bit index addressing.
 */
package gpfg_pkg;
	// ---------------------------------------------------------------
	// register map (indices on the plain register port)
	// ---------------------------------------------------------------
	localparam logic [3:0] GPFG_ADR_F_DATA = 4'h0; // first port data latch
	localparam logic [3:0] GPFG_ADR_F_DIR  = 4'h1; // first port direction
	localparam logic [3:0] GPFG_ADR_G_DATA = 4'h2; // second port data latch
	localparam logic [3:0] GPFG_ADR_G_DIR  = 4'h3; // second port direction
	localparam logic [3:0] GPFG_ADR_G_PUL  = 4'h4; // second port pull-up control
	localparam logic [3:0] GPFG_ADR_CTRL   = 4'h5; // standby pin state / ext reset
	// ---------------------------------------------------------------
	// pin masks and fields
	// ---------------------------------------------------------------
	localparam logic [7:0] GPFG_F_MASK     = 8'h07; // bits 0..2 have pins
	localparam logic [7:0] GPFG_G_MASK     = 8'h06; // bits 1..2 have pins
	localparam logic [7:0] GPFG_CTRL_MASK  = 8'h03; // two control bits
	localparam int         GPFG_SPL_BIT    = 0;     // standby pin state bit
	localparam int         GPFG_EXTERNAL_RESET_ENABLE_BIT_BIT  = 1;     // external reset enable bit
	localparam int         GPFG_RST_PIN    = 2;     // first-port pin that is reset
	localparam logic [7:0] GPFG_RST_DIR    = 8'h00; // direction reset value
	localparam logic [7:0] GPFG_RST_LATCH  = 8'h00; // latch reset value (not given)
	localparam logic [7:0] GPFG_RST_CTRL   = 8'h00; // control reset value
	localparam logic [7:0] GPFG_ZERO       = 8'h00; // unmapped read value
	localparam logic [2:0] GPFG_F_OD       = 3'h0;  // open-drain select per F pin
	localparam logic [2:0] GPFG_G_OD       = 3'h0;  // open-drain select per G pin
endpackage

// >>> rtl/gpfg_ports.sv
/*
 * gpfg_ports: direction, latch, pull-up and standby logic for a three-pin
 * and a two-pin port. Assumes one-cycle strobes from the register master
 * and pins that are resolved from the out/oe signals by the surroundings.
 */
`timescale 1ns/1ps
// How it works
// - direction bit 1 output, 0 input
// - output pin drives its latch value
// - writes always update latch only
// - output pin read returns latch
// - input pin read returns pin level
// - read-modify-write read returns latch always
// - reset clears all direction bits
// - standby with bit set: hi-Z, input low
// - standby with bit clear: nothing changes
// - pull-up control bit connects pull-up
// - low output drops pull-up always
// - open-drain latch one gives hi-Z
// - reset enable steals first port pin 2
// - F uses bits 0-2, G bits 1-2
// - peripheral input pin still reads level
module gpfg_ports (
	input  wire logic                sys_clk,      // 125 MHz system clock
	input  wire logic                nrst,         // async reset, active low
	input  wire logic [3:0]          reg_addr,     // register index
	input  wire logic [7:0]          reg_wdata,    // write data
	input  wire logic                reg_wr,       // write strobe
	input  wire logic                reg_rd,       // read strobe
	input  wire logic                reg_rmw,      // read is read-modify-write
	output logic      [7:0]          reg_rdata,    // read data, cycle after strobe
	input  wire logic                standby_stop, // device in stop or watch mode
	input  wire logic [2:0]          pf_in,        // first port pin levels
	output logic      [2:0]          pf_out,       // first port drive value
	output logic      [2:0]          pf_oe,        // first port drive enable
	input  wire logic [2:1]          pg_in,        // second port pin levels
	output logic      [2:1]          pg_out,       // second port drive value
	output logic      [2:1]          pg_oe,        // second port drive enable
	output logic      [2:1]          pg_pullup,    // second port pull-up connect
	output logic                     ext_reset_sel // pin 2 of first port is reset
);
	import gpfg_pkg::*;

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [7:0] f_lat_r, f_lat_nxt;   // first port latch
	logic [7:0] f_dir_r, f_dir_nxt;   // first port direction
	logic [7:0] g_lat_r, g_lat_nxt;   // second port latch
	logic [7:0] g_dir_r, g_dir_nxt;   // second port direction
	logic [7:0] g_pul_r, g_pul_nxt;   // second port pull-up control
	logic [7:0] ctrl_r, ctrl_nxt;     // standby pin state and reset enable
	logic [7:0] rdata_r, rdata_nxt;   // read data register
	// pin synchronisers: first stage feeds only the second
	logic [2:0] pf_s1_r, pf_s2_r;
	logic [2:1] pg_s1_r, pg_s2_r;
	logic [7:0] f_pin, g_pin;         // sampled levels after gating
	logic       park;                 // pins parked for standby

	// ---------------------------------------------------------------
	// pin input sampling
	// ---------------------------------------------------------------
	// two flops because pins are asynchronous to sys_clk
	// cost: a pin change reaches a read two cycles late, which software
	// never notices but a bench must allow for
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pf_s1_r <= 3'h0;
			pf_s2_r <= 3'h0;
			pg_s1_r <= 2'h0;
			pg_s2_r <= 2'h0;
		end else begin
			pf_s1_r <= pf_in;
			pf_s2_r <= pf_s1_r;
			pg_s1_r <= pg_in;
			pg_s2_r <= pg_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// pin drive and pull-up
	// ---------------------------------------------------------------
	// standby_stop comes from the same clock domain, so no sync here;
	// a pin-side mode signal would need the two-flop stage as well
	// park only when bit set and in standby
	assign park = ctrl_r[GPFG_SPL_BIT] & standby_stop;
	assign ext_reset_sel = ctrl_r[GPFG_EXTERNAL_RESET_ENABLE_BIT_BIT];

	// per-pin drive; holds levels when the bit is clear
	// open-drain selects are constants, so the float term folds away
	// on pins that are push-pull
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pf_out[i] = f_lat_r[i];
			pf_oe[i] = f_dir_r[i] & ~park & ~(GPFG_F_OD[i] & f_lat_r[i]);
		end
		// reset pin has no port drive
		if (ctrl_r[GPFG_EXTERNAL_RESET_ENABLE_BIT_BIT]) begin
			pf_oe[GPFG_RST_PIN] = 1'b0;
		end
		for (int i = 1; i < 3; i++) begin
			pg_out[i] = g_lat_r[i];
			pg_oe[i] = g_dir_r[i] & ~park & ~(GPFG_G_OD[i - 1] & g_lat_r[i]);
			pg_pullup[i] = g_pul_r[i] & ~(pg_oe[i] & ~g_lat_r[i]) & ~park;
		end
	end

	// sampled levels; forces blocked inputs low
	// forcing low rather than holding keeps a floating parked pin
	// from feeding a stale level into a later read
	always_comb begin
		f_pin = GPFG_ZERO;
		g_pin = GPFG_ZERO;
		if (!park) begin
			f_pin[2:0] = pf_s2_r;
			g_pin[2:1] = pg_s2_r;
		end
		if (ctrl_r[GPFG_EXTERNAL_RESET_ENABLE_BIT_BIT]) begin
			f_pin[GPFG_RST_PIN] = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// register writes and reads
	// ---------------------------------------------------------------
	// next-state for all software registers and the read data
	// a write and a read never share a cycle, so the two case
	// statements below never fight over one register
	always_comb begin
		f_lat_nxt = f_lat_r;
		f_dir_nxt = f_dir_r;
		g_lat_nxt = g_lat_r;
		g_dir_nxt = g_dir_r;
		g_pul_nxt = g_pul_r;
		ctrl_nxt  = ctrl_r;
		rdata_nxt = rdata_r;
		if (reg_wr) begin
			unique case (reg_addr)
				GPFG_ADR_F_DATA: f_lat_nxt = reg_wdata & GPFG_F_MASK;
				GPFG_ADR_F_DIR:  f_dir_nxt = reg_wdata & GPFG_F_MASK;
				GPFG_ADR_G_DATA: g_lat_nxt = reg_wdata & GPFG_G_MASK;
				GPFG_ADR_G_DIR:  g_dir_nxt = reg_wdata & GPFG_G_MASK;
				GPFG_ADR_G_PUL:  g_pul_nxt = reg_wdata & GPFG_G_MASK;
				GPFG_ADR_CTRL:   ctrl_nxt  = reg_wdata & GPFG_CTRL_MASK;
				default: ;       // unmapped write ignored
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				GPFG_ADR_F_DATA: rdata_nxt = reg_rmw ? f_lat_r :
					((f_dir_r & f_lat_r) | (~f_dir_r & f_pin)) & GPFG_F_MASK;
				GPFG_ADR_F_DIR:  rdata_nxt = f_dir_r;
				GPFG_ADR_G_DATA: rdata_nxt = reg_rmw ? g_lat_r :
					((g_dir_r & g_lat_r) | (~g_dir_r & g_pin)) & GPFG_G_MASK;
				GPFG_ADR_G_DIR:  rdata_nxt = g_dir_r;
				GPFG_ADR_G_PUL:  rdata_nxt = g_pul_r;
				GPFG_ADR_CTRL:   rdata_nxt = ctrl_r;
				default:         rdata_nxt = GPFG_ZERO; // unmapped reads zero
			endcase
		end
	end

	// register the software state
	// reset values are constants only, so reset never depends on logic
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			f_lat_r <= GPFG_RST_LATCH;
			f_dir_r <= GPFG_RST_DIR;
			g_lat_r <= GPFG_RST_LATCH;
			g_dir_r <= GPFG_RST_DIR;
			g_pul_r <= GPFG_RST_LATCH;
			ctrl_r  <= GPFG_RST_CTRL;
			rdata_r <= GPFG_ZERO;
		end else begin
			f_lat_r <= f_lat_nxt;
			f_dir_r <= f_dir_nxt;
			g_lat_r <= g_lat_nxt;
			g_dir_r <= g_dir_nxt;
			g_pul_r <= g_pul_nxt;
			ctrl_r  <= ctrl_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// read data straight from a flop: it holds until the next read,
	// so a slow master may still look one cycle late
	assign reg_rdata = rdata_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_g_lat_wr;
		reg_wr && reg_addr == GPFG_ADR_G_DATA;
	endsequence

	sequence s_f_rd_norm;
		reg_rd && !reg_rmw && reg_addr == GPFG_ADR_F_DATA;
	endsequence

	sequence s_unmapped_wr;
		reg_wr && reg_addr > GPFG_ADR_CTRL;
	endsequence

	AST_DIR_DRIVE: assert property (f_dir_r[0] && !park |-> pf_oe[0])
		else $error("output direction not driving");
	AST_LATCH_PIN: assert property (s_g_lat_wr ##1 (g_dir_r[1] && !park)
		|-> pg_out[1] == $past(reg_wdata[1]))
		else $error("pin does not show latch");
	AST_IN_NODRIVE: assert property (!f_dir_r[1] |-> !pf_oe[1])
		else $error("input pin driven");
	AST_RD_OUT: assert property (reg_rd && reg_addr == GPFG_ADR_F_DATA && f_dir_r[0]
		|=> reg_rdata[0] == $past(f_lat_r[0]))
		else $error("output read not latch");
	AST_RD_IN: assert property (reg_rd && !reg_rmw && reg_addr == GPFG_ADR_G_DATA
		&& !g_dir_r[2] && !park |=> reg_rdata[2] == $past(pg_s2_r[2]))
		else $error("input read not pin");
	AST_RMW: assert property (reg_rd && reg_rmw && reg_addr == GPFG_ADR_G_DATA
		|=> reg_rdata == $past(g_lat_r))
		else $error("rmw read not latch");
	AST_PARK: assert property (park |-> pf_oe == 3'h0 && pg_oe == 2'h0)
		else $error("pin driven while parked");
	AST_PULL_LOW: assert property (pg_oe[2] && !pg_out[2] |-> !pg_pullup[2])
		else $error("pull-up on low output");
	AST_RST_PIN: assert property (ext_reset_sel |-> !pf_oe[2])
		else $error("reset pin driven");
	AST_PINLESS: assert property (##1 g_lat_r[0] == 1'b0 && f_dir_r[7:3] == 5'h0)
		else $error("pinless bit stored");
	AST_DIR_RESET: assert property ($rose(nrst)
		|-> f_dir_r == GPFG_RST_DIR && g_dir_r == GPFG_RST_DIR)
		else $error("direction not cleared by reset");
	AST_PARK_READ: assert property (s_f_rd_norm ##0 (park && !f_dir_r[0])
		|=> reg_rdata[0] == 1'b0)
		else $error("parked input not low");
	AST_STBY_KEEP: assert property (!ctrl_r[GPFG_SPL_BIT] && f_dir_r[1] |-> pf_oe[1])
		else $error("drive lost with pin-state bit clear");
	AST_PULL_ON: assert property (g_pul_r[1] && !park && !(pg_oe[1] && !pg_out[1])
		|-> pg_pullup[1])
		else $error("pull-up not connected");
	AST_PULL_OFF: assert property (!g_pul_r[2] |-> !pg_pullup[2])
		else $error("pull-up connected while off");
	AST_OD_FLOAT: assert property (GPFG_G_OD[1] && g_lat_r[2] |-> !pg_oe[2])
		else $error("open-drain pin driven high");
	AST_F_MAP: assert property (pf_out == f_lat_r[2:0])
		else $error("first port pin map wrong");
	AST_G_MAP: assert property (pg_out == g_lat_r[2:1])
		else $error("second port pin map wrong");
	AST_RD_PERIPH: assert property (s_f_rd_norm ##0 (!f_dir_r[1] && !park)
		|=> reg_rdata[1] == $past(pf_s2_r[1]))
		else $error("shared input read not pin");
	AST_WR_IGNORE: assert property (s_unmapped_wr
		|=> $stable(f_lat_r) && $stable(ctrl_r) && $stable(g_lat_r))
		else $error("unmapped write changed state");
endmodule

// >>> verification/gpfg_board.sv
/*
 * gpfg_board: board-side wiring for the five port pins.
 * Assumes the bench chooses whether the board drives and with what.
 */
`timescale 1ns/1ps
module gpfg_board (
	input  wire logic       sys_clk,   // pattern clock
	input  wire logic       brd_en,    // board drives released pins
	input  wire logic [2:0] brd_f,     // board level, first port
	input  wire logic [2:1] brd_g,     // board level, second port
	input  wire logic [2:0] pf_out,    // design drive value
	input  wire logic [2:0] pf_oe,     // design drive enable
	input  wire logic [2:1] pg_out,    // design drive value
	input  wire logic [2:1] pg_oe,     // design drive enable
	input  wire logic [2:1] pg_pullup, // design pull-up connect
	output logic      [2:0] pf_in,     // resolved wire, first port
	output logic      [2:1] pg_in      // resolved wire, second port
);
	logic alt_r = 1'b0; // floating wire flips so no stale level passes
	always_ff @(posedge sys_clk) begin
		alt_r <= ~alt_r;
	end
	// no peripheral drives here
	// design drive wins, then board, then pull-up, else float
	always_comb begin
		for (int i = 0; i < 3; i++) pf_in[i] = pf_oe[i] ? pf_out[i] : brd_en ? brd_f[i] : alt_r;
		for (int i = 1; i < 3; i++)
			pg_in[i] = pg_oe[i] ? pg_out[i] : brd_en ? brd_g[i] : (pg_pullup[i] | alt_r);
	end
endmodule

// >>> verification/tb_top.sv
/*
 * tb_top: self-checking bench for the two-port gpio block.
 * Assumes the board model resolves every pin wire.
 */
`timescale 1ns/1ps
module tb_top;
	import gpfg_pkg::*;
	logic       sys_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, reg_rmw = 0;
	logic       standby_stop = 0, brd_en = 1, ext_sel;
	logic [3:0] reg_addr = 0, ad;
	logic [7:0] reg_wdata = 0, reg_rdata, lat, dir, bv, msk;
	logic [2:0] pf_in, pf_out, pf_oe, brd_f = 0;
	logic [2:1] pg_in, pg_out, pg_oe, pg_pullup, brd_g = 0;
	int         err_total = 0, comparisons = 0, cyc = 0, p;
	logic [7:0] mdl [0:5] = '{default: 8'h00}; // model of stored registers
	gpfg_ports i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw),
		.reg_rdata(reg_rdata), .standby_stop(standby_stop), .pf_in(pf_in), .pf_out(pf_out),
		.pf_oe(pf_oe), .pg_in(pg_in), .pg_out(pg_out), .pg_oe(pg_oe),
		.pg_pullup(pg_pullup), .ext_reset_sel(ext_sel));
	gpfg_board i_brd (.sys_clk(sys_clk), .brd_en(brd_en), .brd_f(brd_f), .brd_g(brd_g),
		.pf_out(pf_out), .pf_oe(pf_oe), .pg_out(pg_out), .pg_oe(pg_oe),
		.pg_pullup(pg_pullup), .pf_in(pf_in), .pg_in(pg_in));
	// ---------------------------------------------------------------
	// clock, hang guard, shared tasks
	// ---------------------------------------------------------------
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// bits that own a pin or a control function
	function automatic logic [7:0] msk_of(input logic [3:0] a);
		return (a == GPFG_ADR_CTRL) ? GPFG_CTRL_MASK :
			(a < GPFG_ADR_G_DATA) ? GPFG_F_MASK : GPFG_G_MASK;
	endfunction
	// one-cycle write strobe; the model stores what the rules keep
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		if (a <= GPFG_ADR_CTRL) mdl[a] = d & msk_of(a);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask
	// data stands from the cycle after the strobe until the next read, so look there
	task automatic rd(input logic [3:0] a, input logic m, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rmw  <= m;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1 chk(reg_rdata, exp); // read value
	endtask
	// two-flop synchroniser plus margin
	task automatic settle();
		repeat (5) @(posedge sys_clk);
		#1;
	endtask
	task automatic close_out();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		p = $urandom(32364);
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(GPFG_ADR_F_DIR, 1'b0, GPFG_RST_DIR);
		rd(GPFG_ADR_G_DIR, 1'b0, GPFG_RST_DIR);
		wr(4'hF, 8'hFF);
		rd(4'hF, 1'b0, GPFG_ZERO);
		// random latch, direction and board levels on both ports
		for (int i = 0; i < 40; i++) begin
			p   = i % 2;
			msk = p ? GPFG_G_MASK : GPFG_F_MASK;
			ad  = p ? GPFG_ADR_G_DATA : GPFG_ADR_F_DATA;
			lat = 8'($urandom);
			dir = 8'($urandom);
			bv  = 8'($urandom);
			brd_f <= bv[2:0];
			brd_g <= bv[2:1];
			wr(ad, lat);
			wr(ad + 4'h1, dir);
			settle();
			rd(ad, 1'b0, ((dir & lat) | (~dir & bv)) & msk);
			rd(ad, 1'b1, lat & msk);
			rd(ad + 4'h1, 1'b0, dir & msk);
			chk(p ? {5'h0, pg_oe, 1'b0} : {5'h0, pf_oe}, dir & msk);
			chk(p ? {5'h0, pg_out & pg_oe, 1'b0} : {5'h0, pf_out & pf_oe}, lat & dir & msk);
		end
		// board released: pull-up against a low and a high driver
		brd_en <= 1'b0;
		wr(GPFG_ADR_G_DIR, 8'h02);
		wr(GPFG_ADR_G_DATA, 8'h00);
		wr(GPFG_ADR_G_PUL, 8'h06);
		settle();
		chk({6'h0, pg_pullup}, 8'h02);
		rd(GPFG_ADR_G_DATA, 1'b0, 8'h04);
		wr(GPFG_ADR_G_DATA, 8'h02);
		settle();
		chk({6'h0, pg_pullup}, 8'h03);
		// standby with and without the pin-state bit
		brd_en <= 1'b1;
		brd_g  <= 2'b11;
		wr(GPFG_ADR_G_DIR, 8'h00);
		wr(GPFG_ADR_F_DIR, 8'h07);
		standby_stop <= 1'b1;
		settle();
		chk({5'h0, pf_oe}, 8'h07);
		wr(GPFG_ADR_CTRL, 8'h01);
		settle();
		chk({1'b0, pf_oe, pg_oe, pg_pullup}, 8'h00);
		rd(GPFG_ADR_G_DATA, 1'b0, 8'h00);
		standby_stop <= 1'b0;
		wr(GPFG_ADR_CTRL, 8'h02);
		settle();
		chk({ext_sel, pf_oe}, 8'h0B);
		for (int a = 0; a < 6; a++) rd(4'(a), 1'b1, mdl[a]);
		close_out();
	end
endmodule
